// ===== logic/jlx_map.vh
// Opcode, field and exception constants for the jump and load execute block
`ifndef JLX_MAP_VH
`define JLX_MAP_VH
`define JLX_OP_SPECIAL      6'h00
`define JLX_OP_REGION_JUMP  6'h02
`define JLX_OP_REGION_CALL  6'h03
`define JLX_OP_LOAD_SBYTE   6'h20
`define JLX_OP_LOAD_UBYTE   6'h24
`define JLX_OP_LOAD_DWORD   6'h37
`define JLX_FN_REG_JUMP     6'h08
`define JLX_FN_REG_CALL     6'h09
`define JLX_FN_WRAP_DSUB    6'h2F
`define JLX_LINK_REG        5'h1F
`define JLX_LINK_OFFSET     32'h0000_0008
`define JLX_REGION_LSB      28
`define JLX_EXC_NONE        2'h0
`define JLX_EXC_REFILL      2'h1
`define JLX_EXC_INVALID     2'h2
`define JLX_EXC_ADDR        2'h3
`endif

// ===== logic/jlx_lane_sel.v
// Byte-lane steering of a fetched quadword for byte and doubleword loads
`timescale 1ns/1ns
`include "jlx_map.vh"
module jlx_lane_sel (
    quad,
    vaddr_lo,
    big_flag,
    is_dword,
    is_signed,
    result
);
    input  wire [127:0] quad;
    input  wire [3:0]   vaddr_lo;
    input  wire         big_flag;
    input  wire         is_dword;
    input  wire         is_signed;
    output reg  [63:0]  result;

    wire [3:0] byte_idx;
    wire       half_sel;
    reg  [7:0] byte_val;

    // Byte lane flips all four bits under big-endian order
    assign byte_idx = vaddr_lo ^ {4{big_flag}};
    // Doubleword half flips only on bit three
    assign half_sel = vaddr_lo[3] ^ big_flag;

    // Extension chosen by load kind
    always @* begin
        byte_val = quad[byte_idx*8 +: 8];
        if (is_dword) begin
            result = half_sel ? quad[127:64] : quad[63:0];
        end else if (is_signed) begin
            result = {{56{byte_val[7]}}, byte_val};
        end else begin
            result = {56'h0, byte_val};
        end
    end
endmodule

// ===== logic/jlx_target_gen.v
// Jump target and link value formation
`timescale 1ns/1ns
`include "jlx_map.vh"
module jlx_target_gen (
    pc,
    instr_index,
    src_val,
    use_reg,
    target,
    link_val
);
    input  wire [31:0] pc;
    input  wire [25:0] instr_index;
    input  wire [31:0] src_val;
    input  wire        use_reg;
    output wire [31:0] target;
    output wire [63:0] link_val;

    wire [31:0] slot_pc;
    wire [31:0] region_tgt;

    // Upper bits come from the slot, so the last word of a region
    // lands in the next region
    assign slot_pc    = pc + 32'h0000_0004;
    assign region_tgt = {slot_pc[31:`JLX_REGION_LSB], instr_index, 2'h0};
    // Register form uses the low word of the source only
    assign target     = use_reg ? src_val : region_tgt;
    // Link is the second instruction after the jump
    assign link_val   = {32'h0, pc + `JLX_LINK_OFFSET};
endmodule

// ===== logic/jlx_exec.v
// Execute stage for jumps, calls, byte and doubleword loads, wrapping subtract
`timescale 1ns/1ns
`include "jlx_map.vh"

// Overview of operation
// - Region target: index shifted, slot upper bits
// - Delay slot executes before control transfers
// - Last region word jumps into next region
// - Region call links register 31 with PC+8
// - Register call links rd, jumps captured source
// - Omitted destination encodes register 31
// - Misaligned register target faults at fetch
// - Register jump uses low source word later
// - Signed byte load sign-extends to 64
// - Unsigned byte load zero-extends to 64
// - Address is offset plus base low word
// - Misaligned doubleword faults before memory access
// - Loads raise only refill, invalid, address error
// - Byte lane XOR with replicated order flag
// - Doubleword picks half by bit three
// - Wrapping subtract never signals overflow
module jlx_exec (
    clk,
    rst_n,
    byte_order_big_flag,
    instr_valid,
    instr,
    instr_pc,
    rs_val,
    rt_val,
    fetch_pc,
    fetch_valid,
    fetch_addr_err,
    redirect,
    redirect_pc,
    wb_en,
    wb_reg,
    wb_data,
    mem_req,
    mem_vaddr,
    mem_paddr_lo,
    mem_dword,
    xlat_refill,
    xlat_invalid,
    mem_paddr_in,
    mem_ack,
    mem_quad,
    busy,
    exc_valid,
    exc_code
);
    input  wire         clk;
    input  wire         rst_n;
    input  wire         byte_order_big_flag;
    input  wire         instr_valid;
    input  wire [31:0]  instr;
    input  wire [31:0]  instr_pc;
    input  wire [63:0]  rs_val;
    input  wire [63:0]  rt_val;
    input  wire [31:0]  fetch_pc;
    input  wire         fetch_valid;
    output wire         fetch_addr_err;
    output reg          redirect;
    output reg  [31:0]  redirect_pc;
    output reg          wb_en;
    output reg  [4:0]   wb_reg;
    output reg  [63:0]  wb_data;
    output wire         mem_req;
    output reg  [31:0]  mem_vaddr;
    output wire [3:0]   mem_paddr_lo;
    output reg          mem_dword;
    input  wire         xlat_refill;
    input  wire         xlat_invalid;
    input  wire [3:0]   mem_paddr_in;
    input  wire         mem_ack;
    input  wire [127:0] mem_quad;
    output wire         busy;
    output reg          exc_valid;
    output reg  [1:0]   exc_code;

    // Load sequencer states
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_MEM  = 3'b010;
    localparam [2:0] ST_DONE = 3'b100;

    wire [5:0]  op;
    wire [5:0]  fn;
    wire [4:0]  rd_f;
    wire [4:0]  rt_f;
    wire        is_rjump;
    wire        is_rcall;
    wire        is_reg_jump;
    wire        is_reg_call;
    wire        is_dsub;
    wire        is_load;
    wire        is_jump;
    wire [31:0] ea;
    wire [31:0] tgt;
    wire [63:0] link_val;
    wire [63:0] load_res;
    wire        ins_wb;
    wire        ld_ret;

    reg  [2:0]  state_r;
    reg  [2:0]  state_nxt;
    reg         pend_r;
    reg  [31:0] pend_pc_r;
    reg  [4:0]  ld_reg_r;
    reg         ld_signed_r;
    reg         order_r;
    reg         order_s1_r;
    reg         park_r;
    reg  [4:0]  park_reg_r;
    reg  [63:0] park_data_r;

    // Field extraction
    assign op   = instr[31:26];
    assign fn   = instr[5:0];
    assign rd_f = instr[15:11];
    assign rt_f = instr[20:16];

    // Decode of the handled instruction set
    assign is_rjump    = instr_valid && op == `JLX_OP_REGION_JUMP;
    assign is_rcall    = instr_valid && op == `JLX_OP_REGION_CALL;
    assign is_reg_jump = instr_valid && op == `JLX_OP_SPECIAL
                         && fn == `JLX_FN_REG_JUMP;
    assign is_reg_call = instr_valid && op == `JLX_OP_SPECIAL
                         && fn == `JLX_FN_REG_CALL;
    assign is_dsub     = instr_valid && op == `JLX_OP_SPECIAL
                         && fn == `JLX_FN_WRAP_DSUB;
    assign is_load     = instr_valid && state_r == ST_IDLE
                         && (op == `JLX_OP_LOAD_SBYTE
                         || op == `JLX_OP_LOAD_UBYTE
                         || op == `JLX_OP_LOAD_DWORD);
    assign is_jump     = is_rjump | is_rcall | is_reg_jump | is_reg_call;

    // Effective address uses the low base word only
    assign ea = {{16{instr[15]}}, instr[15:0]} + rs_val[31:0];

    jlx_target_gen u_tgt (
        .pc          (instr_pc),
        .instr_index (instr[25:0]),
        .src_val     (rs_val[31:0]),
        .use_reg     (is_reg_jump | is_reg_call),
        .target      (tgt),
        .link_val    (link_val)
    );

    jlx_lane_sel u_lane (
        .quad      (mem_quad),
        .vaddr_lo  (mem_vaddr[3:0]),
        .big_flag  (order_r),
        .is_dword  (mem_dword),
        .is_signed (ld_signed_r),
        .result    (load_res)
    );

    // Byte order pin is held static, still synchronised for safety
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            order_s1_r <= 1'b0;
            order_r    <= 1'b0;
        end else begin
            order_s1_r <= byte_order_big_flag;
            order_r    <= order_s1_r;
        end
    end

    // Fault belongs to the fetch of the target, not the jump itself
    assign fetch_addr_err = fetch_valid && fetch_pc[1:0] != 2'h0;

    // Physical lane bits get the same order flip as virtual ones
    assign mem_paddr_lo = mem_paddr_in ^ {4{order_r}};
    assign mem_req      = state_r == ST_MEM;
    assign busy         = state_r != ST_IDLE;

    // Instruction results own the write port; a load answer that meets
    // one is parked until a free port cycle instead of being dropped
    assign ins_wb = is_rcall | is_reg_call | is_dsub;
    assign ld_ret = state_r == ST_MEM && mem_ack
                    && !xlat_refill && !xlat_invalid;

    // Load sequencer next state
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (is_load && !(op == `JLX_OP_LOAD_DWORD
                    && ea[2:0] != 3'h0)) begin
                    state_nxt = ST_MEM;
                end
            end
            ST_MEM: begin
                if (xlat_refill || xlat_invalid || mem_ack) begin
                    state_nxt = ST_DONE;
                end
            end
            ST_DONE: begin
                // Stay busy until a parked result is written
                if (!park_r) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // Jump target held for one instruction so the slot runs first
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_r      <= 1'b0;
            pend_pc_r   <= 32'h0;
            redirect    <= 1'b0;
            redirect_pc <= 32'h0;
        end else begin
            redirect <= 1'b0;
            if (is_jump && !pend_r) begin
                pend_r    <= 1'b1;
                pend_pc_r <= tgt;
            end else if (pend_r && instr_valid) begin
                pend_r      <= 1'b0;
                redirect    <= 1'b1;
                redirect_pc <= pend_pc_r;
            end
        end
    end

    // Writeback, load tracking and exceptions
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r     <= ST_IDLE;
            wb_en       <= 1'b0;
            wb_reg      <= 5'h0;
            wb_data     <= 64'h0;
            mem_vaddr   <= 32'h0;
            mem_dword   <= 1'b0;
            ld_reg_r    <= 5'h0;
            ld_signed_r <= 1'b0;
            exc_valid   <= 1'b0;
            exc_code    <= `JLX_EXC_NONE;
            park_r      <= 1'b0;
            park_reg_r  <= 5'h0;
            park_data_r <= 64'h0;
        end else begin
            state_r   <= state_nxt;
            wb_en     <= 1'b0;
            exc_valid <= 1'b0;
            if (is_rcall) begin
                wb_en   <= 1'b1;
                wb_reg  <= `JLX_LINK_REG;
                wb_data <= link_val;
            end else if (is_reg_call) begin
                // Assembler encodes 31 when destination is omitted
                wb_en   <= 1'b1;
                wb_reg  <= rd_f;
                wb_data <= link_val;
            end else if (is_dsub) begin
                // Modulo result, overflow never checked
                wb_en   <= 1'b1;
                wb_reg  <= rd_f;
                wb_data <= rs_val - rt_val;
            end else if (park_r) begin
                wb_en   <= 1'b1;
                wb_reg  <= park_reg_r;
                wb_data <= park_data_r;
            end else if (ld_ret) begin
                wb_en   <= 1'b1;
                wb_reg  <= ld_reg_r;
                wb_data <= load_res;
            end
            // Parked answer leaves on the first free port cycle
            if (park_r && !ins_wb) begin
                park_r <= 1'b0;
            end else if (ld_ret && ins_wb) begin
                park_r      <= 1'b1;
                park_reg_r  <= ld_reg_r;
                park_data_r <= load_res;
            end
            // Load issue and alignment check
            if (is_load) begin
                mem_vaddr   <= ea;
                mem_dword   <= op == `JLX_OP_LOAD_DWORD;
                ld_reg_r    <= rt_f;
                ld_signed_r <= op == `JLX_OP_LOAD_SBYTE;
                if (op == `JLX_OP_LOAD_DWORD && ea[2:0] != 3'h0) begin
                    exc_valid <= 1'b1;
                    exc_code  <= `JLX_EXC_ADDR;
                end
            end
            // Translation faults cancel the write; only two kinds, refill and invalid
            if (state_r == ST_MEM) begin
                if (xlat_refill) begin
                    exc_valid <= 1'b1;
                    exc_code  <= `JLX_EXC_REFILL;
                end else if (xlat_invalid) begin
                    exc_valid <= 1'b1;
                    exc_code  <= `JLX_EXC_INVALID;
                end
            end
        end
    end
endmodule

// ===== bench/jlx_exec_assertions.sv
// Concurrent checks on the execute block ports
`timescale 1ns/1ns
`include "jlx_map.vh"
module jlx_exec_assertions (
    input wire         clk,
    input wire         rst_n,
    input wire         byte_order_big_flag,
    input wire         instr_valid,
    input wire [31:0]  instr,
    input wire [31:0]  instr_pc,
    input wire [63:0]  rs_val,
    input wire [63:0]  rt_val,
    input wire [31:0]  fetch_pc,
    input wire         fetch_valid,
    input wire         fetch_addr_err,
    input wire         redirect,
    input wire [31:0]  redirect_pc,
    input wire         wb_en,
    input wire [4:0]   wb_reg,
    input wire [63:0]  wb_data,
    input wire         mem_req,
    input wire [31:0]  mem_vaddr,
    input wire [3:0]   mem_paddr_lo,
    input wire [3:0]   mem_paddr_in,
    input wire         xlat_refill,
    input wire         busy,
    input wire         exc_valid,
    input wire [1:0]   exc_code
);
    // Decoded fields and expected arithmetic
    wire [5:0]  op   = instr[31:26];
    wire [5:0]  fn   = instr[5:0];
    wire [31:0] ea   = rs_val[31:0] + {{16{instr[15]}}, instr[15:0]};
    wire [31:0] link = instr_pc + `JLX_LINK_OFFSET;
    wire [63:0] diff = rs_val - rt_val;
    wire        sp   = instr_valid && op == `JLX_OP_SPECIAL;
    wire        dw   = op == `JLX_OP_LOAD_DWORD;
    wire        ld   = instr_valid && !busy && (dw ||
                       op == `JLX_OP_LOAD_SBYTE || op == `JLX_OP_LOAD_UBYTE);
    wire        mis  = dw && ea[2:0] != 3'h0;
    wire        bf   = byte_order_big_flag;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // A jump followed at once by its slot instruction
    sequence s_rgn;
        instr_valid && (op == `JLX_OP_REGION_JUMP ||
            op == `JLX_OP_REGION_CALL) ##1 instr_valid;
    endsequence
    sequence s_reg;
        sp && (fn == `JLX_FN_REG_JUMP || fn == `JLX_FN_REG_CALL)
            ##1 instr_valid;
    endsequence
    AST_RGN_TGT: assert property (s_rgn |=> redirect &&
        redirect_pc == {$past(instr_pc[31:28]), $past(instr[25:0], 2), 2'h0})
        else $error("region target wrong");
    AST_REG_TGT: assert property (s_reg |=> redirect &&
        redirect_pc == $past(rs_val[31:0], 2)) else $error("reg target wrong");
    AST_RGN_LINK: assert property (instr_valid &&
        op == `JLX_OP_REGION_CALL |=> wb_en && wb_reg == `JLX_LINK_REG &&
        wb_data == {32'h0, $past(link)}) else $error("region link wrong");
    AST_REG_LINK: assert property (sp && fn == `JLX_FN_REG_CALL |=>
        wb_en && !exc_valid && wb_reg == $past(instr[15:11]) &&
        wb_data == {32'h0, $past(link)}) else $error("reg link wrong");
    AST_WRAP_SUB: assert property (sp && fn == `JLX_FN_WRAP_DSUB |=>
        wb_en && !exc_valid && wb_data == $past(diff))
        else $error("subtract wrong");
    AST_DW_ALIGN: assert property (ld && mis |=>
        exc_valid && exc_code == `JLX_EXC_ADDR && !mem_req)
        else $error("dword alignment fault wrong");
    AST_LD_ADDR: assert property (ld && !mis |=>
        mem_req && mem_vaddr == $past(ea)) else $error("load address wrong");
    AST_LANE: assert property (mem_req && bf == $past(bf) &&
        bf == $past(bf, 2) |-> mem_paddr_lo == (mem_paddr_in ^ {4{bf}}))
        else $error("physical lane wrong");
    AST_REFILL: assert property (mem_req && xlat_refill |=>
        exc_valid && exc_code == `JLX_EXC_REFILL && !wb_en)
        else $error("refill fault wrong");
    AST_FETCH: assert property (fetch_addr_err ==
        (fetch_valid && fetch_pc[1:0] != 2'h0)) else $error("fetch fault wrong");
endmodule
bind jlx_exec jlx_exec_assertions jlx_exec_assertions_inst (.*);

// ===== bench/jlx_mem_model.sv
// Translator and quadword memory stand-in for loads
`timescale 1ns/1ns
module jlx_mem_model (
    input  wire         clk,
    input  wire         rst_n,
    input  wire         mem_req,
    input  wire [31:0]  mem_vaddr,
    input  wire [3:0]   dly,
    input  wire [1:0]   fault,
    output reg          mem_ack,
    output reg          xlat_refill,
    output reg          xlat_invalid,
    output wire [3:0]   mem_paddr_in,
    output wire [127:0] mem_quad
);
    reg [3:0]   cnt;
    reg [127:0] pat;
    integer     i;
    // Byte k holds {k, A}: low lanes positive, high lanes negative
    always @* for (i = 0; i < 16; i = i + 1) pat[8*i+:8] = {i[3:0], 4'hA};
    // Identity low bits; idle lines carry the inverse, never stale data
    assign mem_paddr_in = mem_req ? mem_vaddr[3:0] : ~mem_vaddr[3:0];
    assign mem_quad = mem_ack ? pat : ~pat;
    // One response pulse after dly stall cycles
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {mem_ack, xlat_refill, xlat_invalid} <= 3'h0;
            cnt <= 4'h0;
        end else begin
            {mem_ack, xlat_refill, xlat_invalid} <= 3'h0;
            cnt <= 4'h0;
            if (mem_req && !(mem_ack || xlat_refill || xlat_invalid)) begin
                if (cnt == dly)
                    {xlat_invalid, xlat_refill, mem_ack} <= 3'h1 << fault;
                else
                    cnt <= cnt + 4'h1;
            end
        end
    end
endmodule

// ===== bench/tb_jlx_exec.sv
// Self-checking bench for the jump and load execute block
`timescale 1ns/1ns
`include "jlx_map.vh"
module tb_jlx_exec;
    logic         clk, rst_n, big, iv, fv, redir, wb_en, mem_req, mdw;
    logic         ack, rfl, inv, busy, exc_v, fae;
    logic [31:0]  ins, ipc, fpc, rpc, vaddr;
    logic [63:0]  rs, rt, wb_d;
    logic [4:0]   wb_r;
    logic [3:0]   plo, pin, dly;
    logic [1:0]   exc_c, flt;
    logic [127:0] quad;
    int           fails, cmp_count, cyc;
    jlx_exec jlx_exec_inst (.clk(clk), .rst_n(rst_n),
        .byte_order_big_flag(big), .instr_valid(iv), .instr(ins),
        .instr_pc(ipc), .rs_val(rs), .rt_val(rt), .fetch_pc(fpc),
        .fetch_valid(fv), .fetch_addr_err(fae), .redirect(redir),
        .redirect_pc(rpc), .wb_en(wb_en), .wb_reg(wb_r), .wb_data(wb_d),
        .mem_req(mem_req), .mem_vaddr(vaddr), .mem_paddr_lo(plo),
        .mem_dword(mdw), .xlat_refill(rfl), .xlat_invalid(inv),
        .mem_paddr_in(pin), .mem_ack(ack), .mem_quad(quad), .busy(busy),
        .exc_valid(exc_v), .exc_code(exc_c));
    jlx_mem_model jlx_mem_model_inst (.clk(clk), .rst_n(rst_n),
        .mem_req(mem_req), .mem_vaddr(vaddr), .dly(dly), .fault(flt),
        .mem_ack(ack), .xlat_refill(rfl), .xlat_invalid(inv),
        .mem_paddr_in(pin), .mem_quad(quad));
    task automatic print_verdict;
        if (fails == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [63:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Inputs change 1 ns after the edge; valid stays up between issues
    task automatic issue(input logic [31:0] i, pc, input logic [63:0] a, b);
        @(posedge clk) #1 {iv, ins, ipc, rs, rt} = {1'h1, i, pc, a, b};
    endtask
    task automatic idle;
        @(posedge clk) #1 iv = 1'h0;
    endtask
    task automatic t_region(input logic [5:0] op, input logic [31:0] pc);
        logic [31:0] s;
        s = pc + 32'h4;
        issue({op, 26'h1234567}, pc, 64'h0, 64'h0);
        issue({16'h0022, 10'h0C0, 6'h2F}, s, 64'h8000_0000_0000_0000, 64'h1);
        chk("redirect", redir, 1'h0);
        if (op == `JLX_OP_REGION_CALL) begin
            chk("wb_reg", wb_r, 5'h1F);
            chk("wb_data", wb_d, {32'h0, pc + 32'h8});
        end
        idle;
        chk("redirect", redir, 1'h1);
        chk("redirect_pc", rpc, {s[31:28], 26'h1234567, 2'h0});
        chk("sub", wb_d, 64'h7FFF_FFFF_FFFF_FFFF);
        chk("exc", exc_v, 1'h0);
    endtask
    task automatic t_reg(input logic [5:0] fn, input logic [4:0] rd,
        input logic [31:0] tgt);
        issue({6'h00, 5'h07, 5'h00, rd, 5'h00, fn}, 32'hFFFF_FFF0,
            {32'hDEAD_0000, tgt}, 64'h0); // rs differs from rd
        issue({16'h0022, 10'h0C0, 6'h2F}, 32'h0, 64'h5, 64'h7);
        chk("exc", exc_v, 1'h0);
        chk("wb_en", wb_en, fn == `JLX_FN_REG_CALL);
        if (fn == `JLX_FN_REG_CALL) begin
            chk("wb_reg", wb_r, rd);
            chk("wb_data", wb_d, 64'hFFFF_FFF8);
        end
        idle;
        chk("redirect", redir, 1'h1);
        chk("redirect_pc", rpc, tgt);
        {fv, fpc} = {1'h1, tgt};
        @(posedge clk) #1 chk("fetch_err", fae, tgt[1:0] != 2'h0);
        fv = 1'h0;
    endtask
    task automatic t_load(input logic [5:0] op, input logic [31:0] base,
        input logic [15:0] off, input logic b, input logic [1:0] f);
        logic [31:0] ea;
        logic [7:0]  by;
        logic [63:0] exp;
        logic [1:0]  ec;
        int          n;
        ea = base + {{16{off[15]}}, off};
        by = {ea[3:0] ^ {4{b}}, 4'hA};
        exp = op == `JLX_OP_LOAD_SBYTE ? {{56{by[7]}}, by} : {56'h0, by};
        for (n = 0; n < 8; n++)
            if (op == `JLX_OP_LOAD_DWORD)
                exp[8*n+:8] = {ea[3] ^ b, n[2:0], 4'hA};
        ec = f != 2'h0 ? f : (op == `JLX_OP_LOAD_DWORD && ea[2:0] != 3'h0) ?
            `JLX_EXC_ADDR : `JLX_EXC_NONE;
        @(posedge clk) #1 {big, flt, dly} = {b, f, 2'h0, ea[1:0]};
        repeat (3) @(posedge clk);
        issue({op, 10'h089, off}, 32'h0, {32'hFFFF_FFFF, base}, 64'h0);
        idle;
        chk("mem_req", mem_req, ec != `JLX_EXC_ADDR);
        chk("busy", busy, ec != `JLX_EXC_ADDR);
        chk("mem_dword", mdw, op == `JLX_OP_LOAD_DWORD);
        if (ec != `JLX_EXC_ADDR) begin
            chk("vaddr", vaddr, ea);
            chk("paddr_lo", plo, ea[3:0] ^ {4{b}});
        end
        for (n = 0; n < 40 && wb_en !== 1'h1 && exc_v !== 1'h1; n++)
            @(posedge clk) #1;
        chk("exc_code", exc_v === 1'h1 ? exc_c : 2'h0, ec);
        if (ec == `JLX_EXC_NONE) begin
            chk("wb_reg", wb_r, 5'h09);
            chk("load", wb_d, exp);
        end
        repeat (2) @(posedge clk);
    endtask
    task automatic t_loads;
        for (int b = 0; b < 2; b++) begin
            t_load(`JLX_OP_LOAD_SBYTE, 32'h1000, 16'hFF09, b[0], 2'h0);
            t_load(`JLX_OP_LOAD_SBYTE, 32'h1000, 16'h0002, b[0], 2'h0);
            t_load(`JLX_OP_LOAD_UBYTE, 32'h2001, 16'h000C, b[0], 2'h0);
            t_load(`JLX_OP_LOAD_DWORD, 32'h3000, 16'hFFF8, b[0], 2'h0);
            t_load(`JLX_OP_LOAD_DWORD, 32'h3000, 16'h0010, b[0], 2'h0);
            t_load(`JLX_OP_LOAD_DWORD, 32'h3000, 16'h0004, b[0], 2'h0);
        end
        t_load(`JLX_OP_LOAD_UBYTE, 32'h0100, 16'h0003, 1'h0, 2'h1);
        t_load(`JLX_OP_LOAD_DWORD, 32'h0100, 16'h0008, 1'h1, 2'h2);
    endtask
    // Load answer meets a subtract write: both land, subtract first
    task automatic t_collide;
        @(posedge clk) #1 {big, flt, dly} = 7'h00;
        repeat (3) @(posedge clk);
        issue({`JLX_OP_LOAD_SBYTE, 10'h089, 16'h000C}, 32'h0,
            64'h1000, 64'h0);
        idle;
        issue({16'h0022, 10'h0C0, 6'h2F}, 32'h4, 64'h9, 64'hA);
        idle;
        chk("wb_en", wb_en, 1'h1);
        chk("wb_reg", wb_r, 5'h06);
        chk("sub", wb_d, 64'hFFFF_FFFF_FFFF_FFFF);
        @(posedge clk) #1;
        chk("wb_en", wb_en, 1'h1);
        chk("wb_reg", wb_r, 5'h09);
        chk("load", wb_d, 64'hFFFF_FFFF_FFFF_FFCA);
        repeat (2) @(posedge clk);
    endtask
    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    // Hang guard well above the few hundred cycles the run needs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            fails++;
            print_verdict;
        end
    end
    initial begin
        {rst_n, big, iv, fv, ins, ipc, fpc, rs, rt, dly, flt} = '0;
        repeat (16) @(posedge clk);
        #1 rst_n = 1'h1;
        repeat (3) @(posedge clk);
        t_region(`JLX_OP_REGION_JUMP, 32'h1000_0040);
        t_region(`JLX_OP_REGION_CALL, 32'h2FFF_FFFC);
        t_reg(`JLX_FN_REG_CALL, 5'h05, 32'h2000_0102);
        t_reg(`JLX_FN_REG_CALL, `JLX_LINK_REG, 32'h0040_0000);
        t_reg(`JLX_FN_REG_JUMP, 5'h00, 32'h1000_0003);
        t_loads;
        t_collide;
        print_verdict;
    end
endmodule
